// [design/ecr_hold_timing.sv]
// bus hold request launch edge selection
`include "ecr_consts.svh"

module ecr_hold_timing (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold_timing_select,
	input wire logic hold_req_in,
	output logic bus_hold_req
);
	import ecr_pkg::*;

	logic fall_q; // request launched on the falling edge
	logic rise_q; // same request half a clock later
	logic next_fall;
	logic next_rise;

	// next values of both launch stages
	always_comb begin
		next_fall = hold_req_in;
		next_rise = fall_q;
	end

	// falling edge stage
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_q <= 1'b0;
		end else begin
			fall_q <= next_fall;
		end
	end

	// rising edge stage, retimes the falling edge copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_q <= 1'b0;
		end else begin
			rise_q <= next_rise;
		end
	end

	// static select; changing it mid-request may shorten one pulse
	assign bus_hold_req = hold_timing_select ? rise_q : fall_q;

	property p_hold_rise;
		@(posedge pclk) disable iff (!presetn)
		hold_timing_select && $past(hold_timing_select)
			|-> bus_hold_req == $past(hold_req_in);
	endproperty
	a_hold_rise: assert property (p_hold_rise) else $error("hold not on rising edge");

	property p_hold_fall;
		@(negedge pclk) disable iff (!presetn)
		!hold_timing_select |=> bus_hold_req == $past(hold_req_in);
	endproperty
	a_hold_fall: assert property (p_hold_fall) else $error("hold not on falling edge");

endmodule

// [design/ecr_media_sel.sv]
// twisted pair / attachment unit port selection
`include "ecr_consts.svh"

module ecr_media_sel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic auto_sel,
	input wire logic tp_link_good,
	input wire logic port_select_pin,
	output ecr_pkg::ecr_port_e active_port
);
	import ecr_pkg::*;

	ecr_port_e next_port; // selection for the next cycle

	// auto mode prefers twisted pair and falls back on a lost link
	always_comb begin
		if (auto_sel) begin
			// the pin is not looked at in auto mode
			next_port = tp_link_good ? ECR_PORT_TP : ECR_PORT_AU;
		end else begin
			next_port = port_select_pin ? ECR_PORT_AU : ECR_PORT_TP;
		end
	end

	// register the choice so the port mux never sees a glitch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_port <= ECR_PORT_TP;
		end else begin
			active_port <= next_port;
		end
	end

	property p_auto_fallback;
		@(posedge pclk) disable iff (!presetn)
		auto_sel && !tp_link_good |=> active_port == ECR_PORT_AU;
	endproperty
	a_auto_fallback: assert property (p_auto_fallback) else $error("auto select did not fall back");

	property p_pin_ignored;
		@(posedge pclk) disable iff (!presetn)
		auto_sel && tp_link_good && port_select_pin
			|=> active_port == ECR_PORT_TP;
	endproperty
	a_pin_ignored: assert property (p_pin_ignored) else $error("select pin obeyed in auto mode");

endmodule

// [design/ecr_top.sv]
// extended configuration register bank with APB slave and interrupts
//
// Implementation choice: register access over APB.
`include "ecr_consts.svh"

// Functional notes
// - hardware reset clears register, levels included
// - soft reset leaves register untouched
// - extended user pins follow level bits
// - extended pins driven only in extended mode
// - heartbeat ignore bit disables heartbeat check
// - jabber off bit disables jabber timer
// - auto select prefers twisted pair link
// - auto select ignores port select pin
// - loopback bit loops twisted pair transceiver
// - hold timing zero launches on falling edge
// - hold timing one launches half clock later
// - alignment counter wrap sets status bit 2
// - missed counter wrap sets status bit 1
// - fifo full without bus sets bit 0
// - compress output on match or miss mode
// - reject on match drops matching packets unless a special accept applies
module ecr_top #(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// system bus side
	input wire logic bus_master,
	output logic [3:0] ext_user_pins,
	output logic ext_user_pins_oe_n,
	input wire logic hold_req_in,
	output logic bus_hold_req,
	output logic soft_reset,
	// network side
	output logic heartbeat_monitor_en,
	output logic jabber_timer_en,
	output logic tp_loopback_en,
	input wire logic tp_link_good,
	input wire logic port_select_pin,
	output ecr_pkg::ecr_port_e active_port,
	// receive path events
	input wire logic alignment_error_event,
	input wire logic missed_packet_event,
	input wire logic rx_fifo_full,
	input wire logic bus_granted,
	input wire ecr_pkg::ecr_match_s rx_match,
	output logic compress_output,
	output logic compress_oe_n,
	output logic pkt_accept
);
	import ecr_pkg::*;

	// ***************************************************************
	// apb decode
	// ***************************************************************
	logic setup; // first cycle of a transfer
	logic access; // second cycle, always ready
	logic wr_en; // write takes effect at this edge
	logic hit_ext, hit_stat, hit_clr, hit_en, hit_pri;
	logic [31:0] next_prdata;
	logic next_pslverr;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_en = access & pwrite;
	// read data is captured in setup, so no wait state is needed
	assign pready = access;
	assign hit_ext = (paddr == `ECR_EXT_ADDR);
	assign hit_stat = (paddr == `ECR_STAT_ADDR);
	assign hit_clr = (paddr == `ECR_CLR_ADDR);
	assign hit_en = (paddr == `ECR_EN_ADDR);
	assign hit_pri = (paddr == `ECR_PRI_ADDR);

	// ***************************************************************
	// register state
	// ***************************************************************
	ecr_ext_cfg_s ext_cfg; // extended_config_reg
	ecr_ext_cfg_s next_ext_cfg;
	logic [15:0] pri_cfg; // primary_bus_config_reg subset
	logic [15:0] next_pri_cfg;
	ecr_irq_t irq_stat; // sticky status
	ecr_irq_t next_irq_stat;
	ecr_irq_t irq_en; // enable mask
	ecr_irq_t next_irq_en;
	ecr_irq_t irq_evt; // this cycle's events
	ecr_irq_t irq_clr; // this cycle's clear strobes
	logic ext_mode; // extended bus mode selected

	assign ext_mode = pri_cfg[`ECR_B_EXTMODE];
	assign soft_reset = pri_cfg[`ECR_B_SRST];

	// read mux and error answer, sampled in the setup cycle
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup) begin
			next_prdata = 32'h0000_0000;
			next_pslverr = ~(hit_ext | hit_stat | hit_clr | hit_en | hit_pri);
			if (hit_ext) begin
				next_prdata = {16'h0000, ext_cfg};
			end else if (hit_stat) begin
				next_prdata = {29'h0000_0000, irq_stat};
			end else if (hit_en) begin
				next_prdata = {29'h0000_0000, irq_en};
			end else if (hit_pri) begin
				next_prdata = {16'h0000, pri_cfg};
			end
		end
	end

	// register writes; soft reset is deliberately not looked at here
	always_comb begin
		next_ext_cfg = ext_cfg;
		next_pri_cfg = pri_cfg;
		next_irq_en = irq_en;
		irq_clr = `ECR_IRQ_RESET;
		if (wr_en && !pslverr) begin
			if (hit_ext) begin
				// reserved bits stay zero whatever is written
				next_ext_cfg = ecr_ext_cfg_s'(pwdata[15:0] & `ECR_EXT_WMASK);
			end
			if (hit_pri) begin
				next_pri_cfg = pwdata[15:0] & `ECR_PRI_WMASK;
			end
			if (hit_en) begin
				next_irq_en = pwdata[2:0];
			end
			if (hit_clr) begin
				irq_clr = pwdata[2:0];
			end
		end
	end

	// sticky status; an event in the clear cycle wins
	always_comb begin
		next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
	end

	// register bank flops; levels reset to zero rather than unknown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_cfg <= ecr_ext_cfg_s'(`ECR_EXT_RESET);
			pri_cfg <= `ECR_PRI_RESET;
			irq_stat <= `ECR_IRQ_RESET;
			irq_en <= `ECR_IRQ_RESET;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			ext_cfg <= next_ext_cfg;
			pri_cfg <= next_pri_cfg;
			irq_stat <= next_irq_stat;
			irq_en <= next_irq_en;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	assign irq = |(irq_stat & irq_en);

	// ***************************************************************
	// tally counters
	// ***************************************************************
	logic [1:0] cnt_inc; // index 1 alignment, index 0 missed
	logic [1:0] cnt_wrap; // counter passes from max to zero
	logic [CNT_W-1:0] cnt [2]; // tally counters

	assign cnt_inc = {alignment_error_event, missed_packet_event};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt
			logic [CNT_W-1:0] next_cnt;
			// wrap is flagged on the same increment that returns to zero
			always_comb begin
				next_cnt = cnt[gi];
				if (cnt_inc[gi]) begin
					next_cnt = cnt[gi] + CNT_W'(`ECR_CNT_ONE);
				end
			end
			assign cnt_wrap[gi] = cnt_inc[gi] && (cnt[gi] == CNT_W'(`ECR_CNT_MAX));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt[gi] <= CNT_W'(`ECR_CNT_RESET);
				end else begin
					cnt[gi] <= next_cnt;
				end
			end
		end
	endgenerate

	// event vector feeding the sticky status
	always_comb begin
		irq_evt = `ECR_IRQ_RESET;
		irq_evt[`ECR_I_ALIGN] = cnt_wrap[1];
		irq_evt[`ECR_I_MISS] = cnt_wrap[0];
		// long bus latency: fifo filled while the bus was not ours
		irq_evt[`ECR_I_OVR] = rx_fifo_full & ~bus_granted;
	end

	// ***************************************************************
	// configuration outputs
	// ***************************************************************
	assign ext_user_pins = ext_cfg.levels;
	// pins float unless mastering the bus in extended mode
	assign ext_user_pins_oe_n = ~(bus_master & ext_mode);
	assign heartbeat_monitor_en = ~ext_cfg.hb_ignore;
	assign jabber_timer_en = ~ext_cfg.jab_off;
	assign tp_loopback_en = ext_cfg.loopback;
	// output floats with both modes off; both on is not supported
	assign compress_oe_n = ~(ext_cfg.cmp_match ^ ext_cfg.cmp_miss);

	// ***************************************************************
	// receive filter decision
	// ***************************************************************
	logic next_compress;
	logic next_accept;

	// one result per filter pulse; broadcast never compresses on miss
	always_comb begin
		next_compress = 1'b0;
		next_accept = 1'b0;
		if (rx_match.valid) begin
			next_compress = (ext_cfg.cmp_match & ~ext_cfg.cmp_miss & rx_match.match)
				| (ext_cfg.cmp_miss & ~ext_cfg.cmp_match & ~rx_match.match
				& ~rx_match.broadcast);
			// reject only masks the table hit, never the special accepts
			next_accept = (rx_match.match & ~ext_cfg.reject)
				| rx_match.special;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compress_output <= 1'b0;
			pkt_accept <= 1'b0;
		end else begin
			compress_output <= next_compress;
			pkt_accept <= next_accept;
		end
	end

	// ***************************************************************
	// submodules
	// ***************************************************************
	ecr_media_sel u_media (
		.pclk(pclk),
		.presetn(presetn),
		.auto_sel(ext_cfg.auto_sel),
		.tp_link_good(tp_link_good),
		.port_select_pin(port_select_pin),
		.active_port(active_port)
	);

	ecr_hold_timing u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.hold_timing_select(ext_cfg.hold_sel),
		.hold_req_in(hold_req_in),
		.bus_hold_req(bus_hold_req)
	);

	// ***************************************************************
	// assertions
	// ***************************************************************
	sequence s_ext_write;
		wr_en && hit_ext && !pslverr;
	endsequence

	property p_reset_clear;
		@(posedge pclk) $rose(presetn)
			|-> ext_cfg == ecr_ext_cfg_s'(`ECR_EXT_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

	property p_soft_keep;
		@(posedge pclk) disable iff (!presetn)
		soft_reset && !(wr_en && hit_ext) |=> $stable(ext_cfg);
	endproperty
	a_soft_keep: assert property (p_soft_keep) else $error("register moved in soft reset");

	property p_pins_drive;
		@(posedge pclk) disable iff (!presetn)
		s_ext_write ##1 (bus_master && ext_mode)
			|-> !ext_user_pins_oe_n && ext_user_pins == $past(pwdata[15:12]);
	endproperty
	a_pins_drive: assert property (p_pins_drive) else $error("user pins not at written levels");

	property p_pins_float;
		@(posedge pclk) disable iff (!presetn)
		!ext_mode |-> ext_user_pins_oe_n;
	endproperty
	a_pins_float: assert property (p_pins_float) else $error("user pins driven outside mode");

	property p_hb_jab;
		@(posedge pclk) disable iff (!presetn)
		s_ext_write |=> heartbeat_monitor_en == !$past(pwdata[11])
			&& jabber_timer_en == !$past(pwdata[9]);
	endproperty
	a_hb_jab: assert property (p_hb_jab) else $error("heartbeat or jabber enable wrong");

	property p_loop;
		@(posedge pclk) disable iff (!presetn)
		// the second look goes two cycles back, a next setup may move pwdata
		s_ext_write |=> tp_loopback_en == $past(pwdata[6])
			##1 tp_loopback_en == $past(pwdata[6], 2);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback enable wrong");

	property p_align_wrap;
		@(posedge pclk) disable iff (!presetn)
		alignment_error_event && cnt[1] == CNT_W'(`ECR_CNT_MAX)
			|=> irq_stat[2] && cnt[1] == CNT_W'(`ECR_CNT_RESET);
	endproperty
	a_align_wrap: assert property (p_align_wrap) else $error("alignment wrap lost");

	property p_miss_wrap;
		@(posedge pclk) disable iff (!presetn)
		missed_packet_event && cnt[0] == CNT_W'(`ECR_CNT_MAX)
			|=> irq_stat[1];
	endproperty
	a_miss_wrap: assert property (p_miss_wrap) else $error("missed wrap lost");

	property p_overrun;
		@(posedge pclk) disable iff (!presetn)
		// interrupt only owed while the overrun bit is enabled
		rx_fifo_full && !bus_granted
			|=> irq_stat[0] && (irq || !irq_en[0]);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag or interrupt missing");

	property p_compress;
		@(posedge pclk) disable iff (!presetn)
		rx_match.valid && (ext_cfg.cmp_match ^ ext_cfg.cmp_miss)
			|=> compress_output == ($past(ext_cfg.cmp_match)
			? $past(rx_match.match)
			: !$past(rx_match.match) && !$past(rx_match.broadcast));
	endproperty
	a_compress: assert property (p_compress) else $error("compress output wrong");

	property p_reject;
		@(posedge pclk) disable iff (!presetn)
		rx_match.valid && rx_match.match && ext_cfg.reject && !rx_match.special
			|=> !pkt_accept;
	endproperty
	a_reject: assert property (p_reject) else $error("matching packet not rejected");

endmodule

// [shared/ecr_consts.svh]
// constants for the extended configuration register bank
`ifndef ECR_CONSTS_SVH
`define ECR_CONSTS_SVH

// ***************************************************************
// address map
// ***************************************************************
`define ECR_ADDR_W 12
// printed register index; byte address is four times it
`define ECR_EXT_CFG_INDEX 8'h3f
`define ECR_EXT_ADDR ({2'b00, `ECR_EXT_CFG_INDEX, 2'b00})
`define ECR_STAT_ADDR 12'h100
`define ECR_CLR_ADDR 12'h104
`define ECR_EN_ADDR 12'h108
`define ECR_PRI_ADDR 12'h10c

// ***************************************************************
// reset values and write masks
// ***************************************************************
`define ECR_EXT_RESET 16'h0000
// reserved bits 10, 7, 5 and 3 are not writable
`define ECR_EXT_WMASK 16'hfb57
`define ECR_PRI_RESET 16'h0000
`define ECR_PRI_WMASK 16'h8001
`define ECR_IRQ_RESET 3'h0
`define ECR_CNT_RESET 16'h0000
`define ECR_CNT_MAX 16'hffff
`define ECR_CNT_ONE 16'h0001

// ***************************************************************
// field positions
// ***************************************************************
`define ECR_B_HB 11
`define ECR_B_JAB 9
`define ECR_B_LOOP 6
`define ECR_B_EXTMODE 15
`define ECR_B_SRST 0
`define ECR_I_ALIGN 2
`define ECR_I_MISS 1
`define ECR_I_OVR 0

`endif

// [shared/ecr_pkg.sv]
// types shared by the extended configuration register bank
package ecr_pkg;

	// ***************************************************************
	// extended configuration register layout, bit 15 first
	// ***************************************************************
	typedef struct packed {
		logic [3:0] levels; // ext_output_levels
		logic hb_ignore; // heartbeat_ignore
		logic rsv10;
		logic jab_off; // jabber_timer_off
		logic auto_sel; // media auto select
		logic rsv7;
		logic loopback; // twisted_pair_loopback
		logic rsv5;
		logic hold_sel; // hold_timing_select
		logic rsv3;
		logic cmp_match; // compress on match
		logic cmp_miss; // compress_on_miss
		logic reject; // reject_on_match
	} ecr_ext_cfg_s;

	// address filter result for one received packet
	typedef struct packed {
		logic valid; // one-cycle pulse, result below is valid
		logic match; // destination hit an address table entry
		logic broadcast; // destination is the broadcast address
		logic special; // broadcast, promiscuous or multicast accept
	} ecr_match_s;

	// sticky interrupt vector
	typedef logic [2:0] ecr_irq_t;

	// network port in use
	typedef enum logic {
		ECR_PORT_TP,
		ECR_PORT_AU
	} ecr_port_e;

endpackage

// [verif/ecr_host.sv]
// host model that issues apb register transfers to the bank
`include "ecr_consts.svh"

module ecr_host (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// ***************************************************************
	// idle bus
	// ***************************************************************
	// bus parked idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// ***************************************************************
	// one transfer, entered just after a rising edge
	// ***************************************************************
	// request held until pready is seen at a rising edge
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		// reserved configuration bits always written as zero
		pwdata <= (a == `ECR_EXT_ADDR) ?
			{wd[31:16], wd[15:0] & `ECR_EXT_WMASK} : wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the bench's cycle guard ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// [verif/test_extended_config_register.sv]
// self-checking bench for the extended configuration register bank
`include "ecr_consts.svh"

`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end

module test_extended_config_register;
	timeunit 1ns;
	timeprecision 1ns;
	import ecr_pkg::*;

	// ***************************************************************
	// signals
	// ***************************************************************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic bus_master, hold_req_in, bus_hold_req, soft_reset, rd_e;
	logic [3:0] ext_user_pins;
	logic ext_user_pins_oe_n, heartbeat_monitor_en, jabber_timer_en;
	logic tp_loopback_en, tp_link_good, port_select_pin;
	ecr_port_e active_port;
	logic alignment_error_event, missed_packet_event;
	logic rx_fifo_full, bus_granted;
	ecr_match_s rx_match;
	logic compress_output, compress_oe_n, pkt_accept;
	logic [15:0] cfg;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;

	ecr_top #(.CNT_W(16)) ecr_top_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
		.bus_master, .ext_user_pins, .ext_user_pins_oe_n, .hold_req_in,
		.bus_hold_req, .soft_reset, .heartbeat_monitor_en,
		.jabber_timer_en, .tp_loopback_en, .tp_link_good,
		.port_select_pin, .active_port, .alignment_error_event,
		.missed_packet_event, .rx_fifo_full, .bus_granted, .rx_match,
		.compress_output, .compress_oe_n, .pkt_accept);

	ecr_host ecr_host_i (.pclk, .prdata, .pready, .pslverr, .psel,
		.penable, .pwrite, .paddr, .pwdata);

	// 100 ns clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ***************************************************************
	// expectations and helpers
	// ***************************************************************
	// miss mode never compresses a broadcast destination
	function automatic logic exp_cmp(logic [15:0] c, ecr_match_s m);
		return (c[2] & !c[1] & m.match) |
			(c[1] & !c[2] & !m.match & !m.broadcast);
	endfunction

	// reject only hits the table, never the special accepts
	function automatic logic exp_acc(logic [15:0] c, ecr_match_s m);
		return (m.match & !c[0]) | m.special;
	endfunction

	function automatic ecr_port_e exp_port(logic a, logic lk, logic pin);
		if (a)
			return lk ? ECR_PORT_TP : ECR_PORT_AU;
		return pin ? ECR_PORT_AU : ECR_PORT_TP;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		@(posedge pclk);
		ecr_host_i.xfer(1'b1, a, d, r, e);
	endtask

	task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge pclk);
		ecr_host_i.xfer(1'b0, a, 32'h0000_0000, rd_v, rd_e);
		`CHK("read data", e, rd_v)
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, well above the event scenario length
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_total++;
			close_out;
		end
	end

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		presetn = 1'b0;
		{bus_master, hold_req_in, tp_link_good, port_select_pin} = 4'h0;
		{alignment_error_event, missed_packet_event} = 2'b00;
		{rx_fifo_full, bus_granted} = 2'b00;
		rx_match = '0;
		void'($urandom(32'h4ceab6f3));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("hb en", 1'b1, heartbeat_monitor_en)
		`CHK("oe_n", 1'b1, ext_user_pins_oe_n)
		chk_reg(`ECR_EXT_ADDR, 32'h0000_0000);
		// soft reset held while the configuration is written
		wr(`ECR_PRI_ADDR, 32'h0000_0001);
		@(negedge pclk);
		`CHK("soft reset", 1'b1, soft_reset)
		repeat (6) begin
			cfg = 16'($urandom());
			wr(`ECR_EXT_ADDR, {16'h0000, cfg});
			cfg = cfg & `ECR_EXT_WMASK;
			@(negedge pclk);
			`CHK("hb en", !cfg[11], heartbeat_monitor_en)
			`CHK("jab en", !cfg[9], jabber_timer_en)
			`CHK("loop", cfg[6], tp_loopback_en)
			chk_reg(`ECR_EXT_ADDR, {16'h0000, cfg});
		end
		wr(`ECR_PRI_ADDR, 32'h0000_0000);
		chk_reg(`ECR_EXT_ADDR, {16'h0000, cfg});
		// extended pins across mode and mastership
		for (int i = 0; i < 4; i++) begin
			wr(`ECR_PRI_ADDR, {16'h0000, i[0], 14'h0000, 1'b1});
			bus_master <= i[1];
			@(negedge pclk);
			`CHK("pins", cfg[15:12], ext_user_pins)
			`CHK("pins oe_n", !(i[0] & i[1]), ext_user_pins_oe_n)
		end
		// port choice for every link and pin level
		for (int a = 0; a < 2; a++) begin
			wr(`ECR_EXT_ADDR, 32'(a) << 8);
			for (int j = 0; j < 4; j++) begin
				@(posedge pclk);
				tp_link_good <= j[0];
				port_select_pin <= j[1];
				@(posedge pclk);
				@(negedge pclk);
				`CHK("port", exp_port(a[0], j[0], j[1]), active_port)
			end
		end
		// hold request launch edge, both timings
		for (int s = 0; s < 2; s++) begin
			wr(`ECR_EXT_ADDR, 32'(s) << 4);
			for (int lv = 1; lv >= 0; lv--) begin
				@(posedge pclk);
				hold_req_in <= lv[0];
				@(negedge pclk);
				#1;
				`CHK("hold fall", s[0] ^ lv[0], bus_hold_req)
				@(posedge pclk);
				#1;
				`CHK("hold rise", lv[0], bus_hold_req)
			end
		end
		// compress and reject over every mode and filter result
		for (int m = 0; m < 8; m++) begin
			cfg = {13'h0000, m[2:0]};
			wr(`ECR_EXT_ADDR, {16'h0000, cfg});
			@(negedge pclk);
			`CHK("cmp oe_n", !(cfg[2] ^ cfg[1]), compress_oe_n)
			for (int k = 0; k < 8; k++) begin
				@(posedge pclk);
				rx_match <= ecr_match_s'({1'b1, k[2:0]});
				@(posedge pclk);
				rx_match <= '0;
				@(negedge pclk);
				`CHK("cmp", exp_cmp(cfg, ecr_match_s'(k[3:0])), compress_output)
				`CHK("acc", exp_acc(cfg, ecr_match_s'(k[3:0])), pkt_accept)
			end
		end
		// tally wrap: 65535 events leave status clear, one more wraps
		wr(`ECR_EN_ADDR, 32'h0000_0007);
		@(posedge pclk);
		{alignment_error_event, missed_packet_event} <= 2'b11;
		repeat (65535) @(posedge pclk);
		{alignment_error_event, missed_packet_event} <= 2'b00;
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0000);
		@(posedge pclk);
		{alignment_error_event, missed_packet_event} <= 2'b11;
		@(posedge pclk);
		{alignment_error_event, missed_packet_event} <= 2'b00;
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0006);
		`CHK("irq set", 1'b1, irq)
		wr(`ECR_EN_ADDR, 32'h0000_0000);
		@(negedge pclk);
		`CHK("irq masked", 1'b0, irq)
		wr(`ECR_EN_ADDR, 32'h0000_0007);
		wr(`ECR_CLR_ADDR, 32'h0000_0006);
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0000);
		// overrun only while the bus is not granted
		@(posedge pclk);
		{rx_fifo_full, bus_granted} <= 2'b11;
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0000);
		bus_granted <= 1'b0;
		@(posedge pclk);
		rx_fifo_full <= 1'b0;
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0001);
		`CHK("irq ovr", 1'b1, irq)
		wr(`ECR_CLR_ADDR, 32'h0000_0001);
		chk_reg(`ECR_STAT_ADDR, 32'h0000_0000);
		// unmapped address answers with an error
		chk_reg(12'h200, 32'h0000_0000);
		`CHK("slverr", 1'b1, rd_e)
		close_out;
	end
endmodule
